/* File: hdl/jtsfb_bridge.sv */
// JTAG to serial flash bridge: pin glue, priority, mode muxing, reconfig
`timescale 1ns/1ps
`default_nettype none
module jtsfb_bridge import jtsfb_pkg::*; (
  input wire logic clk, // System clock, 25 MHz
  input wire logic srst, // Synchronous reset, active high
  input wire logic jtag_tck, // JTAG test clock pin
  input wire logic jtag_tms, // JTAG mode select pin
  input wire logic jtag_tdi, // JTAG data in pin
  output logic jtag_tdo, // JTAG data out pin
  output logic jtag_tdo_oe, // TDO drive enable
  input wire logic bridge_sel, // Bridge user instruction selected
  input wire logic bridge_loaded, // Bridge design configured
  input wire logic reconfig_instr, // Reconfiguration pulse instruction seen
  input wire logic jtag_attempt, // JTAG configuration attempted
  input wire logic as_attempt, // Active-serial configuration attempted
  input wire logic config_done_line, // Shared done line, may be held low
  input wire logic [MODE_W-1:0] mode_select_straps, // Mode strap pins
  input wire logic flash_serial_input, // Data from the flash
  output logic serial_flash_clock, // Clock to the flash
  output logic serial_command_out, // Data to the flash, or data bit one
  output logic flash_select_n, // Flash select, or parallel flash select
  input wire logic par_data1, // Parallel data bit one from user logic
  input wire logic par_flash_ce_n, // Parallel flash select from user logic
  input wire logic user_ce_out, // User value for the chip enable output
  input wire logic user_ce_oe, // User drive enable for chip enable output
  output logic chain_ce_out, // Chip enable output pin value
  output logic chain_ce_oe, // Chip enable output drive enable
  output logic as_abort, // Active-serial configuration abandoned
  output logic jtag_grant, // JTAG configuration proceeds
  output logic user_mode, // Device in user mode with the bridge
  output logic reconfig_req, // Reset request to the configuration core
  output logic strap_is_as, // Straps selected active-serial
  output logic config_done_seen // Synchronised done line level
);
  // ==========================================================
  // Pin synchronisers
  localparam int NSYNC = 10 + MODE_W;
  logic [NSYNC-1:0] raw_pins;
  logic [NSYNC-1:0] sync_pins;
  assign raw_pins = {mode_select_straps, config_done_line, as_attempt, jtag_attempt,
                     reconfig_instr, bridge_loaded, bridge_sel, flash_serial_input,
                     jtag_tdi, jtag_tms, jtag_tck};
  jtsfb_sync #(.WIDTH(NSYNC)) u_sync (
    .clk(clk),
    .srst(srst),
    .async_in(raw_pins),
    .sync_out(sync_pins)
  );
  wire tck_s = sync_pins[0];
  wire tms_s = sync_pins[1];
  wire tdi_s = sync_pins[2];
  wire fsi_s = sync_pins[3];
  wire sel_s = sync_pins[4];
  wire loaded_s = sync_pins[5];
  wire pulse_s = sync_pins[6];
  wire jtag_att_s = sync_pins[7];
  wire as_att_s = sync_pins[8];
  wire done_s = sync_pins[9];
  wire [MODE_W-1:0] mode_s = sync_pins[NSYNC-1:10];

  // ==========================================================
  // Edge detection on synchronised levels
  logic tck_d;
  logic pulse_d;
  always_ff @(posedge clk) begin
    if (srst) begin
      tck_d <= 1'b0;
      pulse_d <= 1'b0;
    end else begin
      tck_d <= tck_s;
      pulse_d <= pulse_s;
    end
  end
  wire tck_rise = tck_s & ~tck_d;
  wire tck_fall = ~tck_s & tck_d;
  wire pulse_rise = pulse_s & ~pulse_d;

  // ==========================================================
  // Strap capture once the cleared synchronisers have refilled after reset
  logic [MODE_W-1:0] mode_latched;
  logic strap_taken;
  logic [SYNC_STAGES-1:0] strap_wait;
  always_ff @(posedge clk) begin
    if (srst) begin
      mode_latched <= '0;
      strap_taken <= 1'b0;
      strap_wait <= '0;
    end else begin
      strap_wait <= {strap_wait[SYNC_STAGES-2:0], 1'b1};
      if (!strap_taken && strap_wait[SYNC_STAGES-1]) begin
        mode_latched <= mode_s;
        strap_taken <= 1'b1;
      end
    end
  end
  // [R2] strap decode
  assign strap_is_as = strap_taken && (mode_latched == MODE_AS);
  wire strap_ap = strap_taken && (mode_latched == MODE_AP);
  wire strap_fpp = strap_taken && (mode_latched == MODE_FPP);

  // ==========================================================
  // Configuration priority: JTAG always wins
  // [R1] JTAG precedence
  assign jtag_grant = jtag_att_s;
  assign as_abort = as_att_s & jtag_att_s;
  assign config_done_seen = done_s;

  // ==========================================================
  // Bridge state machine
  jtsfb_state_t state;
  jtsfb_state_t next_state;
  logic [RCNT_W-1:0] rcnt;
  // Shift window: user instruction chosen and TMS low keeps shifting
  wire shift_act = sel_s & ~tms_s;
  wire may_bridge = user_mode & strap_is_as;
  wire rcnt_done = (rcnt == RCNT_W'(RECONF_CYC - 1));
  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        // [R9] only the host instruction leads to reconfig
        if (pulse_rise && user_mode) begin
          next_state = ST_RECONF;
        end else if (shift_act && may_bridge) begin
          next_state = ST_XFER;
        end
      end
      ST_XFER: begin
        if (pulse_rise) begin
          next_state = ST_RECONF;
        end else if (!shift_act) begin
          next_state = ST_IDLE;
        end
      end
      ST_RECONF: next_state = ST_RECONF;
      default: next_state = ST_IDLE;
    endcase
  end

  // State, user mode and reconfig counter
  always_ff @(posedge clk) begin
    if (srst) begin
      state <= ST_IDLE;
      user_mode <= 1'b0;
      rcnt <= '0;
      reconfig_req <= 1'b0;
    end else begin
      state <= next_state;
      // [R7] done line deliberately ignored
      if (loaded_s && state != ST_RECONF) begin
        user_mode <= 1'b1;
      end
      // [R11] reset pulse, then bridge gone until reset
      if (next_state == ST_RECONF) begin
        user_mode <= 1'b0;
        reconfig_req <= !(state == ST_RECONF && rcnt_done) && !(state == ST_RECONF && !reconfig_req);
        if (state == ST_RECONF && reconfig_req) begin
          rcnt <= rcnt_done ? rcnt : rcnt + 1'b1;
        end
      end
    end
  end

  // ==========================================================
  // Flash pin glue; TCK fall launches data, rise clocks the flash
  logic sclk;
  logic sdo;
  logic sel_n;
  logic tdo_q;
  wire in_xfer = (state == ST_XFER);
  always_ff @(posedge clk) begin
    if (srst) begin
      sclk <= SCLK_IDLE;
      sdo <= 1'b0;
      sel_n <= SELECT_IDLE;
      tdo_q <= 1'b0;
    end else begin
      // [R15] idle levels outside transfers
      sel_n <= !(next_state == ST_XFER);
      // [R5] flash clock follows TCK in a transfer
      if (in_xfer && tck_rise) begin
        sclk <= 1'b1;
      end else if (!in_xfer || tck_fall) begin
        sclk <= SCLK_IDLE;
      end
      // [R8] JTAG data forwarded to the flash
      if (in_xfer && tck_fall) begin
        sdo <= tdi_s;
      end
      // [R3] flash data returned on TDO
      if (in_xfer && tck_rise) begin
        tdo_q <= fsi_s;
      end
    end
  end

  // ==========================================================
  // Dual-purpose pins; AP mode hands both to user logic, FPP mode only command out
  logic par_ce_q;
  logic par_d1_q;
  always_ff @(posedge clk) begin
    if (srst) begin
      par_ce_q <= SELECT_IDLE;
      par_d1_q <= 1'b0;
    end else begin
      par_ce_q <= par_flash_ce_n;
      par_d1_q <= par_data1;
    end
  end
  // [R13] mode-dependent pin function
  assign flash_select_n = strap_ap ? par_ce_q : sel_n;
  assign serial_command_out = (strap_ap || strap_fpp) ? par_d1_q : sdo;
  // [R4] glue output to flash pins
  assign serial_flash_clock = sclk;
  assign jtag_tdo = tdo_q;
  assign jtag_tdo_oe = in_xfer;
  // [R14] chip enable output as user pin
  assign chain_ce_out = user_ce_out;
  assign chain_ce_oe = user_ce_oe & user_mode;

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  property p_jtag_prio;
    jtag_attempt && as_attempt |-> ##2 as_abort && jtag_grant;
  endproperty
  a_jtag_prio: assert property (p_jtag_prio) else $error("JTAG lost priority"); // [R1]

  property p_idle_pins;
    state == ST_IDLE && !strap_ap |=> flash_select_n || $past(next_state) == ST_XFER;
  endproperty
  a_idle_pins: assert property (p_idle_pins) else $error("Select low while idle"); // [R15]

  property p_enter_xfer;
    state == ST_IDLE && shift_act && may_bridge && !pulse_rise && !strap_ap
      |=> !flash_select_n && state == ST_XFER;
  endproperty
  a_enter_xfer: assert property (p_enter_xfer) else $error("Shift not bridged"); // [R4]

  property p_clk_follow;
    in_xfer && tck_rise && next_state == ST_XFER |=> serial_flash_clock ##1 !tck_fall [*1];
  endproperty
  a_clk_follow: assert property (p_clk_follow) else $error("Flash clock missed edge"); // [R5]

  property p_data_fwd;
    in_xfer && tck_fall && !strap_ap && !strap_fpp |=> serial_command_out == $past(tdi_s);
  endproperty
  a_data_fwd: assert property (p_data_fwd) else $error("TDI not forwarded"); // [R8]

  property p_tdo_ret;
    in_xfer && tck_rise |=> jtag_tdo == $past(fsi_s);
  endproperty
  a_tdo_ret: assert property (p_tdo_ret) else $error("Flash data not returned"); // [R3]

  property p_user_mode;
    loaded_s && !done_s && state != ST_RECONF && next_state != ST_RECONF |=> user_mode;
  endproperty
  a_user_mode: assert property (p_user_mode) else $error("User mode blocked by done line"); // [R7]

  property p_no_self_reconf;
    $rose(reconfig_req) |-> $past(pulse_rise);
  endproperty
  a_no_self_reconf: assert property (p_no_self_reconf) else $error("Reconfig without host"); // [R9]

  property p_reconf_pulse;
    $rose(reconfig_req) |-> reconfig_req [*5] ##1 !reconfig_req && !user_mode;
  endproperty
  a_reconf_pulse: assert property (p_reconf_pulse) else $error("Bad reconfig pulse"); // [R11]

  property p_ap_select;
    strap_ap |=> flash_select_n == $past(par_flash_ce_n) || $rose(strap_ap);
  endproperty
  a_ap_select: assert property (p_ap_select) else $error("Parallel select not passed"); // [R13]

  c_xfer: cover property (state == ST_IDLE ##1 state == ST_XFER);
  c_abort: cover property ($rose(as_abort));
  c_reconf: cover property ($rose(reconfig_req));
endmodule
`default_nettype wire

/* File: hdl/jtsfb_sync.sv */
// Two-flop synchroniser bank for pins from outside the clock domain
`timescale 1ns/1ps
`default_nettype none
module jtsfb_sync import jtsfb_pkg::*; #(
  parameter int WIDTH = 1
) (
  input wire logic clk, // System clock
  input wire logic srst, // Synchronous reset, active high
  input wire logic [WIDTH-1:0] async_in, // Raw pin levels
  output logic [WIDTH-1:0] sync_out // Levels safe to use
);
  // ==========================================================
  // One pair of flops per bit; the first is read only by the second
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      logic [SYNC_STAGES-1:0] stage;
      always_ff @(posedge clk) begin
        if (srst) begin
          stage <= '0;
        end else begin
          stage <= {stage[SYNC_STAGES-2:0], async_in[i]};
        end
      end
      assign sync_out[i] = stage[SYNC_STAGES-1];
    end
  endgenerate
endmodule
`default_nettype wire

/* File: shared/jtsfb_pkg.sv */
// Shared constants and types of the JTAG to serial flash bridge
// Contract
// [R1] Simultaneous JTAG and active-serial attempts: JTAG wins, active-serial aborts.
// [R2] Board straps mode select inputs to the active-serial scheme.
// [R3] Host programs the flash using only the four JTAG pins.
// [R4] Glue logic carries JTAG accesses out onto the serial flash pins.
// [R5] Bridge drives flash clock, command out, select and reads flash data.
// [R6] Host configures only the master device in a chain.
// [R7] Master enters user mode though config done line is held low.
// [R8] Programming data arrives over JTAG, then goes to the flash.
// [R9] After flash programming the device never starts reconfiguration itself.
// [R10] Host issues the reconfiguration pulse instruction when programming completes.
// [R11] On reconfiguration the master resets and the bridge stops existing.
// [R12] Chip enable input is grounded or driven low for JTAG configuration.
// [R13] Select output doubles as parallel flash select; command out as data bit one.
// [R14] Chip enable output may be unused or serve as a user pin.
// [R15] Select stays high and clock idle outside JTAG flash transactions.
`default_nettype none
package jtsfb_pkg;
  // ==========================================================
  // Mode select strap codes
  localparam int MODE_W = 4;
  localparam logic [MODE_W-1:0] MODE_AS = 4'h2;
  localparam logic [MODE_W-1:0] MODE_AP = 4'h4;
  localparam logic [MODE_W-1:0] MODE_FPP = 4'hc;
  // ==========================================================
  // Timing of the reconfiguration request pulse
  localparam int CLK_NS = 40;
  localparam int RECONF_PULSE_NS = 200;
  localparam int RECONF_CYC = (RECONF_PULSE_NS + CLK_NS - 1) / CLK_NS;
  localparam int RCNT_W = 4;
  // ==========================================================
  // Synchroniser depth and reset levels
  localparam int SYNC_STAGES = 2;
  localparam logic SELECT_IDLE = 1'b1;
  localparam logic SCLK_IDLE = 1'b0;
  // ==========================================================
  // Bridge states, one-hot
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_XFER = 3'b010,
    ST_RECONF = 3'b100
  } jtsfb_state_t;
endpackage
`default_nettype wire

/* File: verification/jtsfb_flash_model.sv */
// Behavioural serial flash standing on the far side of the bridge
`timescale 1ns/1ps
`default_nettype none
module jtsfb_flash_model #(
  parameter logic [7:0] READ_PATTERN = 8'ha5 // Bits returned, MSB first
) (
  input wire logic serial_flash_clock, // Clock from the bridge
  input wire logic serial_command_out, // Data from the bridge
  input wire logic flash_select_n, // Select from the bridge, active low
  output logic flash_serial_input, // Data back to the bridge
  output logic [7:0] rx_byte // Last eight bits taken in
);
  // ==========================================================
  // Receive side
  logic [7:0] tx;
  initial begin
    rx_byte = 8'h00;
    tx = READ_PATTERN;
    flash_serial_input = 1'b0;
  end
  always @(posedge serial_flash_clock) begin
    if (!flash_select_n) begin
      rx_byte <= {rx_byte[6:0], serial_command_out};
    end
  end
  // ==========================================================
  // Transmit side
  // First bit on select
  always @(negedge flash_select_n) begin
    tx = READ_PATTERN;
    flash_serial_input = tx[7];
  end
  // Next bit on falling clock, so it is settled before the next rise
  always @(negedge serial_flash_clock) begin
    if (!flash_select_n) begin
      tx = {tx[6:0], 1'b0};
      flash_serial_input = tx[7];
    end
  end
  // Released line has no pull, so show the inverse rather than stale data
  always @(posedge flash_select_n) begin
    flash_serial_input = ~flash_serial_input;
  end
endmodule
`default_nettype wire

/* File: verification/testbench.sv */
// Self-checking bench of the JTAG to serial flash bridge
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import jtsfb_pkg::*;
  localparam logic [7:0] READ_PAT = 8'ha5;
  logic clk, srst, tck, tms, tdi, bsel, loaded, rinstr, jatt, aatt, cdone;
  logic pd1, pce_n, uce, uce_oe, fsi, tdo, tdo_oe, fclk, fcmd, fsel_n;
  logic ce_out, ce_oe, abort, grant, umode, rreq, is_as, dseen;
  logic [MODE_W-1:0] straps;
  logic [7:0] rx;
  int mismatches = 0;
  int n_compared = 0;
  int cyc = 0;
  // ==========================================================
  // Design and far side
  // Chip enable input is grounded on the board, so the bridge has no pin
  jtsfb_bridge i_jtsfb_bridge (.clk(clk), .srst(srst), .jtag_tck(tck), .jtag_tms(tms),
    .jtag_tdi(tdi), .jtag_tdo(tdo), .jtag_tdo_oe(tdo_oe), .bridge_sel(bsel),
    .bridge_loaded(loaded), .reconfig_instr(rinstr), .jtag_attempt(jatt),
    .as_attempt(aatt), .config_done_line(cdone), .mode_select_straps(straps),
    .flash_serial_input(fsi), .serial_flash_clock(fclk), .serial_command_out(fcmd),
    .flash_select_n(fsel_n), .par_data1(pd1), .par_flash_ce_n(pce_n),
    .user_ce_out(uce), .user_ce_oe(uce_oe), .chain_ce_out(ce_out), .chain_ce_oe(ce_oe),
    .as_abort(abort), .jtag_grant(grant), .user_mode(umode), .reconfig_req(rreq),
    .strap_is_as(is_as), .config_done_seen(dseen));
  jtsfb_flash_model #(.READ_PATTERN(READ_PAT)) i_jtsfb_flash_model (
    .serial_flash_clock(fclk), .serial_command_out(fcmd), .flash_select_n(fsel_n),
    .flash_serial_input(fsi), .rx_byte(rx));
  // ==========================================================
  // Clock, timeout and common tasks
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // Whole run needs about 350 cycles; a hang is cut well beyond that
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      results();
    end
  end
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string msg);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %0t %s: got %h want %h", $time, msg, seen, exp);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic results();
    if (mismatches == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // Straps must be steady well before release, so set them with reset
  task automatic do_reset(input logic [MODE_W-1:0] m);
    @(negedge clk);
    srst = 1'b1;
    straps = m;
    wt(8);
    srst = 1'b0;
    wt(4);
  endtask
  // ==========================================================
  // Scenarios
  task automatic t_idle();
    chk(fsel_n, 1'b1, "idle select");
    chk(fclk, 1'b0, "idle clock");
    chk(rreq, 1'b0, "reconf at reset");
    chk(is_as, 1'b1, "as straps");
    bsel = 1'b1;
    tms = 1'b0;
    wt(6);
    chk(fsel_n, 1'b1, "select before load");
    bsel = 1'b0;
    tms = 1'b1;
  endtask
  // Done line held low by unconfigured slaves must not block user mode
  task automatic t_user();
    // only this master is loaded; slaves stay blank
    loaded = 1'b1;
    uce = 1'b1;
    uce_oe = 1'b1;
    wt(6);
    chk(umode, 1'b1, "user mode");
    chk(dseen, 1'b0, "done line");
    chk(ce_out, 1'b1, "ce out");
    chk(ce_oe, 1'b1, "ce enable");
    uce = 1'b0;
    wt(1);
    chk(ce_out, 1'b0, "ce out low");
  endtask
  task automatic t_prio();
    jatt = 1'b1;
    wt(5);
    chk({grant, abort}, 8'h02, "jtag only");
    aatt = 1'b1;
    wt(5);
    chk({grant, abort}, 8'h03, "both attempts");
    jatt = 1'b0;
    wt(5);
    chk(abort, 1'b0, "as alone");
    aatt = 1'b0;
  endtask
  // Nine TCK cycles of 320 ns: TDO carries the byte on the first eight rises, the flash takes it on the last eight
  task automatic t_xfer(input logic [7:0] b);
    logic [8:0] d;
    logic [8:0] got;
    d = {b, 1'b0};
    got = '0;
    bsel = 1'b1;
    tms = 1'b0;
    wt(5);
    chk({fsel_n, tdo_oe}, 8'h01, "window open");
    // TDI moves mid TCK low, clear of the fall that samples it
    for (int i = 0; i < 9; i++) begin
      wt(2);
      tdi = d[8 - i];
      wt(2);
      tck = 1'b1;
      wt(4);
      got = {got[7:0], tdo};
      tck = 1'b0;
    end
    wt(8);
    chk(rx, b, "flash received");
    chk(got[8:1], READ_PAT, "tdo bits");
    tms = 1'b1;
    wt(5);
    chk({fsel_n, fclk, tdo_oe}, 8'h04, "window closed");
    bsel = 1'b0;
    // Let the closed window settle before another one opens
    wt(4);
  endtask
  task automatic t_reconf();
    logic [7:0] hi;
    hi = 8'h00;
    repeat (60) begin
      wt(1);
      hi = hi + {7'h00, rreq};
    end
    chk(hi, 8'h00, "no self reconf");
    // host sends the reconfiguration pulse instruction
    rinstr = 1'b1;
    repeat (20) begin
      wt(1);
      hi = hi + {7'h00, rreq};
    end
    chk(hi, 8'h05, "reconf pulse");
    chk(umode, 1'b0, "bridge gone");
    bsel = 1'b1;
    tms = 1'b0;
    wt(6);
    chk(fsel_n, 1'b1, "refused after reconf");
    {bsel, tms, rinstr} = 3'h2;
  endtask
  // Parallel straps: AP select and command pins, and FPP command pin, carry the user signals
  task automatic t_mode();
    do_reset(MODE_AP);
    chk(is_as, 1'b0, "ap straps");
    {pce_n, pd1} = 2'h1;
    wt(2);
    chk({fsel_n, fcmd}, 8'h01, "ap pins");
    {pce_n, pd1} = 2'h2;
    wt(2);
    chk({fsel_n, fcmd}, 8'h02, "ap pins idle");
    do_reset(MODE_FPP);
    pd1 = 1'b1;
    wt(2);
    chk(fcmd, 1'b1, "fpp data one");
    pd1 = 1'b0;
    wt(2);
    chk(fcmd, 1'b0, "fpp data zero");
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    srst = 1'b1;
    {tck, tms, tdi, bsel, loaded, rinstr, jatt, aatt, cdone} = 9'h080;
    {pd1, pce_n, uce, uce_oe} = 4'h4;
    straps = MODE_AS;
    do_reset(MODE_AS);
    t_idle();
    t_user();
    t_prio();
    t_xfer(8'h96);
    t_xfer(8'h5a);
    t_reconf();
    t_mode();
    results();
  end
endmodule
`default_nettype wire
